/* File: logic/timer_defs.vh */
// constants for the capture/compare/pwm timer
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH
`define TMR_MODE_OFF     2'h0
`define TMR_MODE_CAPTURE 2'h1
`define TMR_MODE_COMPARE 2'h2
`define TMR_MODE_PWM     2'h3
`define TMR_CH_COUNT     3
`define TMR_DT_WIDTH     8
`define TMR_DT_IDLE      8'h00
`define TMR_SYNC_RESET   4'h0
`endif

/* File: logic/capture_compare_pwm_timer.v */
// capture/compare/pwm timer with three channels, dead time and event triggers
`timescale 1ns/1ps
`include "timer_defs.vh"

module capture_compare_pwm_timer #(
	parameter CNT_WIDTH   = 16,
	parameter HAS_DEADTIME = 1
) (
	input  wire                   clk_i,
	input  wire                   rst_b_i,
	input  wire                   enable_i,
	input  wire                   count_ext_i,
	input  wire                   ext_event_i,
	input  wire [2:0]             cap_event_i,
	input  wire [5:0]             ch_mode_i,
	input  wire [3*CNT_WIDTH-1:0] ch_compare_i,
	input  wire                   dt_enable_i,
	input  wire [7:0]             dt_cycles_i,
	output reg  [CNT_WIDTH-1:0]   count_o,
	output reg  [3*CNT_WIDTH-1:0] capture_o,
	output reg  [2:0]             capture_valid_o,
	output reg  [2:0]             ch_out_o,
	output reg  [2:0]             ch_out_n_o,
	output reg                    overflow_trig_o,
	output reg  [2:0]             match_trig_o
);

////////////////////////////////////////////////////////////////////////////////
// pin synchroniser: three stages, change counted when stages two and three agree
reg  [3:0] sync_a;
reg  [3:0] sync_b;
reg  [3:0] sync_c;
reg  [3:0] stable;
reg  [3:0] stable_d;
wire [3:0] pins = {ext_event_i, cap_event_i};
wire [3:0] rise = stable & ~stable_d;
reg  [3:0] next_stable;

// all four bits are taken together, only once stages two and three agree on every pin, so a pin that
// changes right at a clock edge cannot leave a one-cycle glitch behind
always @* begin
	next_stable = stable;
	if (sync_b == sync_c) begin
		next_stable = sync_c;
	end
end

always @(posedge clk_i) begin
	if (!rst_b_i) begin
		sync_a   <= `TMR_SYNC_RESET;
		sync_b   <= `TMR_SYNC_RESET;
		sync_c   <= `TMR_SYNC_RESET;
		stable   <= `TMR_SYNC_RESET;
		stable_d <= `TMR_SYNC_RESET;
	end else begin
		sync_a   <= pins;
		sync_b   <= sync_a;
		sync_c   <= sync_b;
		stable   <= next_stable;
		stable_d <= stable;
	end
end

////////////////////////////////////////////////////////////////////////////////
// counter; external counting uses the filtered rise of the event pin
wire                 tick  = enable_i & (count_ext_i ? rise[3] : 1'b1);
wire [CNT_WIDTH-1:0] all_1 = {CNT_WIDTH{1'b1}};
wire [CNT_WIDTH-1:0] one   = {{(CNT_WIDTH-1){1'b0}}, 1'b1};
wire                 wrap  = tick & (count_o == all_1);
reg  [CNT_WIDTH-1:0] next_count;

// the sum stays at counter width, so all ones rolls over to zero
always @* begin
	next_count = count_o;
	if (tick) begin
		next_count = count_o + one;
	end
end

always @(posedge clk_i) begin
	if (!rst_b_i) begin
		count_o         <= {CNT_WIDTH{1'b0}};
		overflow_trig_o <= 1'b0;
	end else begin
		count_o         <= next_count;
		overflow_trig_o <= wrap;
	end
end

////////////////////////////////////////////////////////////////////////////////
// channel helpers shared by all three channels
wire [CNT_WIDTH-1:0]     zero   = {CNT_WIDTH{1'b0}};
wire                     reload = wrap | (count_o == zero);
wire [`TMR_CH_COUNT-1:0] next_out;
wire [`TMR_CH_COUNT-1:0] next_out_n;
wire [`TMR_CH_COUNT-1:0] cap_take;
wire [`TMR_CH_COUNT-1:0] cmp_hit;
integer                  j;

////////////////////////////////////////////////////////////////////////////////
// per-channel decode, shadow and dead time; the pwm threshold that drives ch_out_o
// and ch_out_n_o is shadowed and reloaded only at the period start, so a written
// value takes effect there, only the last one written in a period, without glitches, while
// match_trig_o in pwm mode compares count_o with the unshadowed threshold
genvar g;
generate
	for (g = 0; g < `TMR_CH_COUNT; g = g + 1) begin : chan
		wire [1:0]           mode     = ch_mode_i[2*g +: 2];
		wire [CNT_WIDTH-1:0] thresh   = ch_compare_i[g*CNT_WIDTH +: CNT_WIDTH];
		wire                 is_cap   = (mode == `TMR_MODE_CAPTURE);
		wire                 is_cmp   = (mode == `TMR_MODE_COMPARE);
		wire                 is_pwm   = (mode == `TMR_MODE_PWM);
		// dead time only separates the complementary pwm pair; a compare
		// output must follow its threshold without blanking
		wire                 dt_on    = (HAS_DEADTIME != 0) && dt_enable_i && is_pwm;
		reg  [CNT_WIDTH-1:0] shadow;
		reg  [7:0]           dt_cnt;
		reg  [7:0]           next_dt_cnt;
		reg                  raw;
		reg                  raw_d;
		reg                  out_q;
		reg                  out_n_q;
		wire                 raw_edge = (raw != raw_d);

		always @* begin
			case (mode)
				`TMR_MODE_COMPARE: begin
					raw = (count_o >= thresh);
				end
				`TMR_MODE_PWM: begin
					raw = (count_o < shadow);
				end
				default: begin
					raw = 1'b0;
				end
			endcase
		end

		// dead time: both outputs low for 1 + dt_cycles clocks after each edge
		always @* begin
			next_dt_cnt = `TMR_DT_IDLE;
			out_q       = raw;
			out_n_q     = ~raw & is_pwm;
			if (dt_on) begin
				if (raw_edge) begin
					next_dt_cnt = dt_cycles_i;
					out_q       = 1'b0;
					out_n_q     = 1'b0;
				end else if (dt_cnt != `TMR_DT_IDLE) begin
					next_dt_cnt = dt_cnt - 8'h01;
					out_q       = 1'b0;
					out_n_q     = 1'b0;
				end
			end
		end

		always @(posedge clk_i) begin
			if (!rst_b_i) begin
				raw_d  <= 1'b0;
				dt_cnt <= `TMR_DT_IDLE;
			end else begin
				raw_d  <= raw;
				dt_cnt <= next_dt_cnt;
			end
		end

		always @(posedge clk_i) begin
			if (!rst_b_i) begin
				shadow <= {CNT_WIDTH{1'b0}};
			end else if (reload) begin
				shadow <= thresh;
			end
		end

		assign next_out[g]   = out_q;
		assign next_out_n[g] = out_n_q;
		assign cap_take[g]   = is_cap & rise[g];
		assign cmp_hit[g]    = (is_cmp | is_pwm) & tick & (count_o == thresh);
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// registered channel outputs and trigger pulses
always @(posedge clk_i) begin
	if (!rst_b_i) begin
		capture_valid_o <= 3'h0;
		ch_out_o        <= 3'h0;
		ch_out_n_o      <= 3'h0;
		match_trig_o    <= 3'h0;
	end else begin
		capture_valid_o <= cap_take;
		ch_out_o        <= next_out;
		ch_out_n_o      <= next_out_n;
		match_trig_o    <= cap_take | cmp_hit;
	end
end

// capture buffers hold their value until the next event on that channel
always @(posedge clk_i) begin
	if (!rst_b_i) begin
		capture_o <= {3*CNT_WIDTH{1'b0}};
	end else begin
		for (j = 0; j < `TMR_CH_COUNT; j = j + 1) begin
			if (cap_take[j]) begin
				capture_o[j*CNT_WIDTH +: CNT_WIDTH] <= count_o;
			end
		end
	end
end

endmodule

/* File: tb/route_sink.sv */
// event routing consumer that counts timer triggers
`timescale 1ns/1ps
module route_sink (
	input  logic clk_i,
	input  logic trig_i,
	output int   hits_o
);
	int hits = 0;
	always @(posedge clk_i) if (trig_i) hits <= hits + 1;
	assign hits_o = hits;
endmodule

/* File: tb/timer_chk_assertions.sv */
// assertions on the timer ports
`timescale 1ns/1ps
module timer_chk #(parameter CNT_WIDTH = 16) (
	input logic                   clk_i,
	input logic                   rst_b_i,
	input logic                   enable_i,
	input logic                   count_ext_i,
	input logic [5:0]             ch_mode_i,
	input logic [3*CNT_WIDTH-1:0] ch_compare_i,
	input logic                   dt_enable_i,
	input logic [CNT_WIDTH-1:0]   count_o,
	input logic [2:0]             capture_valid_o,
	input logic [2:0]             ch_out_o,
	input logic [2:0]             ch_out_n_o,
	input logic                   overflow_trig_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	a_rst_clear: assert property (disable iff (1'b0) !rst_b_i |=> count_o == 0 && ch_out_o == 0)
		else $error("reset");
	a_step_one: assert property (enable_i && !count_ext_i |=> count_o == $past(count_o) + 1'b1)
		else $error("step");
	a_ext_step: assert property ($past(enable_i) && $past(count_ext_i) |->
		count_o == $past(count_o) || count_o == $past(count_o) + 1'b1) else $error("ext");
	a_wrap_pulse: assert property (overflow_trig_o |-> (count_o == 0 || $past(count_o) == 0)
		##1 !overflow_trig_o) else $error("wrap");
	a_cmp_out: assert property ($past(rst_b_i) && $past(ch_mode_i[1:0]) == 2'h2 |-> ch_out_o[0]
		== ($past(count_o) >= $past(ch_compare_i[CNT_WIDTH-1:0]))) else $error("cmp");
	a_off_low: assert property ($past(rst_b_i) && $past(ch_mode_i[1:0]) == 2'h0 |-> !ch_out_o[0])
		else $error("off");
	a_no_overlap: assert property ((ch_out_o & ch_out_n_o) == 3'h0) else $error("overlap");
	a_dead_gap: assert property ($fell(ch_out_o[2]) && dt_enable_i |=> !ch_out_n_o[2])
		else $error("dead");
	a_cap_pulse: assert property (capture_valid_o[1] |=> !capture_valid_o[1])
		else $error("cap");
endmodule
bind capture_compare_pwm_timer timer_chk #(.CNT_WIDTH(CNT_WIDTH)) timer_chk_i (.*);

/* File: tb/capture_compare_pwm_timer_test.sv */
// bench for the capture/compare/pwm timer, counter cut to 8 bits for short wraps
`timescale 1ns/1ps
module capture_compare_pwm_timer_test;
	logic        clk_i = 0, rst_b_i = 0, enable_i = 0, count_ext_i = 0, ext_event_i = 0;
	logic        dt_enable_i = 1, overflow_trig_o;
	logic [2:0]  cap_event_i = 0, capture_valid_o, ch_out_o, ch_out_n_o, match_trig_o;
	logic [5:0]  ch_mode_i = 6'h34;
	logic [7:0]  dt_cycles_i = 8'h02, count_o, c0;
	logic [23:0] ch_compare_i = 24'h400010, capture_o;
	int          miscompares, compares, hits, hits_m, i;
	capture_compare_pwm_timer #(.CNT_WIDTH(8)) capture_compare_pwm_timer_i (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .enable_i(enable_i), .count_ext_i(count_ext_i),
		.ext_event_i(ext_event_i), .cap_event_i(cap_event_i), .ch_mode_i(ch_mode_i),
		.ch_compare_i(ch_compare_i), .dt_enable_i(dt_enable_i), .dt_cycles_i(dt_cycles_i),
		.count_o(count_o), .capture_o(capture_o), .capture_valid_o(capture_valid_o),
		.ch_out_o(ch_out_o), .ch_out_n_o(ch_out_n_o), .overflow_trig_o(overflow_trig_o),
		.match_trig_o(match_trig_o));
	route_sink route_sink_i (.clk_i(clk_i), .trig_i(overflow_trig_o), .hits_o(hits));
	route_sink route_sink_m (.clk_i(clk_i), .trig_i(match_trig_o[0]), .hits_o(hits_m));
	always #5 clk_i = ~clk_i;
	initial begin #100000; miscompares++; results; end
	task check(input string what, input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task results;
		if (miscompares == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task upto(input logic [7:0] v);
		for (int k = 0; k < 600 && count_o !== v; k++) @(posedge clk_i) #1;
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1;
		enable_i <= 1;
		#1 check("reset", count_o, 0);
		repeat (5) @(posedge clk_i);
		ch_mode_i <= 6'h36;
		#1 check("count", count_o, 5);
		upto(8'h10);
		check("cmp lo", ch_out_o[0], 0);
		@(posedge clk_i) #1 check("cmp hi", ch_out_o[0], 1);
		check("cmp n", ch_out_n_o[0], 0);
		c0 = count_o;
		@(posedge clk_i) cap_event_i <= 3'h2;
		for (i = 0; i < 12 && capture_valid_o[1] !== 1; i++) @(posedge clk_i) #1;
		check("cap", (capture_o[15:8] - c0) inside {[3:8]}, 1);
		@(posedge clk_i) cap_event_i <= 0;
		upto(0);
		check("wrap", count_o, 0);
		@(posedge clk_i) count_ext_i <= 1;
		#1 c0 = count_o;
		for (i = 0; i < 6; i++) begin
			repeat (8) @(posedge clk_i);
			ext_event_i <= ~ext_event_i;
		end
		repeat (8) @(posedge clk_i);
		count_ext_i <= 0;
		#1 check("ext", count_o - c0, 3);
		for (i = 0; i < 2; i++) begin
			@(posedge clk_i) ch_compare_i[23:16] <= i ? 8'h20 : 8'h40;
			upto(0);
			upto(8'h30);
			check("pwm", ch_out_o[2], !i);
			check("pwm n", ch_out_n_o[2], i);
		end
		check("trig", hits > 1, 1);
		check("match", hits_m > 1, 1);
		results;
	end
endmodule
